// ### hw/exec_pkg.sv
// Purpose: Shared constants and types for the skip, lookup and xor execute unit
// Assumes: Wishbone classic slave, 32-bit data, byte addresses, 100 MHz clock
// Notes:   Summary of operation below, one line per behaviour; load-to-register and test-for-zero have no line
// Summary of operation
// - Bit-clear skip tests the chosen operand bit and skips the next instruction when it is 0.
// - The bit-set skip tests the chosen operand bit and skips the next instruction when it is 1.
// - Load-and-test copies the operand to the accumulator and skips when the value is zero.
// - Increment-to-accumulator writes operand plus one to the accumulator and skips on zero.
// - Increment-to-register writes operand plus one back to the register and skips on zero.
// - Decrement-to-accumulator writes operand minus one to the accumulator and skips on zero.
// - Decrement-to-register writes operand minus one back to the register and skips on zero.
// - Lookup-to-register: low byte to the register, high byte to the high result, 2 cycles.
// - Lookup-to-accumulator: low byte to the accumulator, high byte to high result, 2 cycles.
// - The lookup address is the high pointer byte followed by the low pointer byte.
// - Xor of immediate or register into the accumulator: one cycle, zero flag only.
// - Xor to register writes operand xor accumulator back to the register, zero flag only.
package exec_pkg;

  localparam int DATA_W   = 8;
  localparam int PMEM_W   = 16;
  localparam int HIGH_W   = PMEM_W - DATA_W;
  localparam int PADDR_W  = 2 * DATA_W;
  localparam int WB_AW    = 8;
  localparam int WB_DW    = 32;
  localparam int SEL_W    = 4;
  localparam int BIT_W    = 3;
  localparam int OP_W     = 4;

  localparam logic [WB_AW-1:0] OFF_CTRL        = 8'h00;
  localparam logic [WB_AW-1:0] OFF_OPERAND     = 8'h04;
  localparam logic [WB_AW-1:0] OFF_ACC         = 8'h08;
  localparam logic [WB_AW-1:0] OFF_PTR_HIGH    = 8'h0C;
  localparam logic [WB_AW-1:0] OFF_PTR_LOW     = 8'h10;
  localparam logic [WB_AW-1:0] OFF_LOOKUP_HIGH = 8'h14;
  localparam logic [WB_AW-1:0] OFF_RESULT      = 8'h18;
  localparam logic [WB_AW-1:0] OFF_STATUS      = 8'h1C;

  localparam int CTRL_OP_LSB  = 0;
  localparam int CTRL_BIT_LSB = 8;
  localparam int SEL_OP       = 0;
  localparam int SEL_BIT      = 1;

  localparam int STAT_BUSY  = 0;
  localparam int STAT_ZERO  = 1;
  localparam int STAT_SKIP  = 2;
  localparam int STAT_REGWR = 3;

  localparam logic [DATA_W-1:0]  BYTE_ZERO  = 8'h00;
  localparam logic [DATA_W-1:0]  BYTE_ONE   = 8'h01;
  localparam logic [HIGH_W-1:0]  HIGH_ZERO  = 8'h00;
  localparam logic [PADDR_W-1:0] PADDR_ZERO = 16'h0000;
  localparam logic [WB_DW-1:0]   WORD_ZERO  = 32'h0000_0000;
  localparam logic [BIT_W-1:0]   BIT_ZERO   = 3'h0;
  localparam logic [OP_W-1:0]    OP_RESET   = 4'h0;

  typedef enum logic [OP_W-1:0] {
    no_operation,
    skip_if_bit_clear,
    skip_if_bit_set,
    load_acc_skip_if_zero,
    load_reg_skip_if_zero,
    inc_to_acc_skip_if_zero,
    inc_reg_skip_if_zero,
    dec_to_acc_skip_if_zero,
    dec_reg_skip_if_zero,
    lookup_to_reg,
    lookup_to_acc,
    test_for_zero,
    xor_immediate_to_acc,
    xor_reg_to_acc,
    xor_reg_to_reg
  } op_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_TABLE,
    ST_DISCARD
  } state_t;

endpackage : exec_pkg

// ### hw/skip_lookup_xor_execute.sv
// Purpose: Executes skip, table lookup and xor instructions for the core
// Assumes: Program memory answers in the same cycle that pmem_rd_o is high; same clock
// Notes:   Operand register stands in for the addressed file register
`timescale 1ns/1ps
`default_nettype none

module skip_lookup_xor_execute (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [exec_pkg::WB_AW-1:0]  wb_adr_i,
  input  wire logic [exec_pkg::SEL_W-1:0]  wb_sel_i,
  input  wire logic [exec_pkg::WB_DW-1:0]  wb_dat_i,
  output var  logic [exec_pkg::WB_DW-1:0]  wb_dat_o,
  output var  logic                        wb_ack_o,
  output var  logic [exec_pkg::PADDR_W-1:0] pmem_addr_o,
  output var  logic                        pmem_rd_o,
  input  wire logic [exec_pkg::PMEM_W-1:0] pmem_data_i,
  output var  logic                        file_we_o,
  output var  logic [exec_pkg::DATA_W-1:0] file_wdata_o,
  output var  logic                        skip_o,
  output var  logic                        busy_o
);

  exec_pkg::state_t             state_r;
  exec_pkg::state_t             state_nxt;
  exec_pkg::op_t                op_r;
  logic [exec_pkg::BIT_W-1:0]   bit_sel_r;
  logic [exec_pkg::DATA_W-1:0]  operand_r;
  logic [exec_pkg::DATA_W-1:0]  acc_r;
  logic [exec_pkg::DATA_W-1:0]  ptr_high_r;
  logic [exec_pkg::DATA_W-1:0]  ptr_low_r;
  logic [exec_pkg::HIGH_W-1:0]  lookup_high_r;
  logic                         zero_r;
  logic                         skip_last_r;
  logic                         reg_wr_last_r;

  logic                         req;
  logic                         wr_req;
  logic                         idle;
  logic                         start;
  logic                         exec;
  logic                         lookup_op;

  logic [exec_pkg::DATA_W-1:0]  res_nxt;
  logic                         to_acc_nxt;
  logic                         to_reg_nxt;
  logic                         skip_nxt;
  logic                         upd_zero_nxt;
  logic [exec_pkg::WB_DW-1:0]   rdata_nxt;

  assign req       = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_req    = req && wb_we_i;
  assign idle      = (state_r == exec_pkg::ST_IDLE);
  assign exec      = (state_r == exec_pkg::ST_EXEC);
  assign start     = wr_req && idle && (wb_adr_i == exec_pkg::OFF_CTRL)
                     && wb_sel_i[exec_pkg::SEL_OP];
  assign lookup_op = (op_r == exec_pkg::lookup_to_reg) || (op_r == exec_pkg::lookup_to_acc);

  // Bus answer one cycle after the request, dropped the cycle after
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  always_comb begin
    rdata_nxt = exec_pkg::WORD_ZERO;
    unique case (wb_adr_i)
      exec_pkg::OFF_CTRL: begin
        rdata_nxt[exec_pkg::CTRL_OP_LSB +: exec_pkg::OP_W]   = op_r;
        rdata_nxt[exec_pkg::CTRL_BIT_LSB +: exec_pkg::BIT_W] = bit_sel_r;
      end
      exec_pkg::OFF_OPERAND:     rdata_nxt[exec_pkg::DATA_W-1:0] = operand_r;
      exec_pkg::OFF_ACC:         rdata_nxt[exec_pkg::DATA_W-1:0] = acc_r;
      exec_pkg::OFF_PTR_HIGH:    rdata_nxt[exec_pkg::DATA_W-1:0] = ptr_high_r;
      exec_pkg::OFF_PTR_LOW:     rdata_nxt[exec_pkg::DATA_W-1:0] = ptr_low_r;
      exec_pkg::OFF_LOOKUP_HIGH: rdata_nxt[exec_pkg::HIGH_W-1:0] = lookup_high_r;
      exec_pkg::OFF_RESULT:      rdata_nxt[exec_pkg::DATA_W-1:0] = file_wdata_o;
      exec_pkg::OFF_STATUS: begin
        rdata_nxt[exec_pkg::STAT_BUSY]  = !idle;
        rdata_nxt[exec_pkg::STAT_ZERO]  = zero_r;
        rdata_nxt[exec_pkg::STAT_SKIP]  = skip_last_r;
        rdata_nxt[exec_pkg::STAT_REGWR] = reg_wr_last_r;
      end
      default: rdata_nxt = exec_pkg::WORD_ZERO;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wb_dat_o <= exec_pkg::WORD_ZERO;
    end else if (req && !wb_we_i) begin
      wb_dat_o <= rdata_nxt;
    end
  end

  // Command register; a write while busy is dropped rather than queued
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      op_r      <= exec_pkg::op_t'(exec_pkg::OP_RESET);
      bit_sel_r <= exec_pkg::BIT_ZERO;
    end else if (wr_req && idle && wb_adr_i == exec_pkg::OFF_CTRL) begin
      if (wb_sel_i[exec_pkg::SEL_OP]) begin
        op_r <= exec_pkg::op_t'(wb_dat_i[exec_pkg::CTRL_OP_LSB +: exec_pkg::OP_W]);
      end
      if (wb_sel_i[exec_pkg::SEL_BIT]) begin
        bit_sel_r <= wb_dat_i[exec_pkg::CTRL_BIT_LSB +: exec_pkg::BIT_W];
      end
    end
  end

  // Operand and pointers frozen while an instruction runs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      operand_r  <= exec_pkg::BYTE_ZERO;
      ptr_high_r <= exec_pkg::BYTE_ZERO;
      ptr_low_r  <= exec_pkg::BYTE_ZERO;
    end else if (wr_req && idle && wb_sel_i[0]) begin
      if (wb_adr_i == exec_pkg::OFF_OPERAND) begin
        operand_r <= wb_dat_i[exec_pkg::DATA_W-1:0];
      end
      if (wb_adr_i == exec_pkg::OFF_PTR_HIGH) begin
        ptr_high_r <= wb_dat_i[exec_pkg::DATA_W-1:0];
      end
      if (wb_adr_i == exec_pkg::OFF_PTR_LOW) begin
        ptr_low_r <= wb_dat_i[exec_pkg::DATA_W-1:0];
      end
    end
  end

  // Datapath for the execute cycle
  always_comb begin
    res_nxt      = operand_r;
    to_acc_nxt   = 1'b0;
    to_reg_nxt   = 1'b0;
    skip_nxt     = 1'b0;
    upd_zero_nxt = 1'b0;
    unique case (op_r)
      exec_pkg::skip_if_bit_clear: begin
        skip_nxt = !operand_r[bit_sel_r];
      end
      exec_pkg::skip_if_bit_set: begin
        skip_nxt = operand_r[bit_sel_r];
      end
      exec_pkg::load_acc_skip_if_zero: begin
        to_acc_nxt = 1'b1;
        skip_nxt   = (operand_r == exec_pkg::BYTE_ZERO);
      end
      exec_pkg::load_reg_skip_if_zero: begin
        to_reg_nxt = 1'b1;
        skip_nxt   = (operand_r == exec_pkg::BYTE_ZERO);
      end
      exec_pkg::inc_to_acc_skip_if_zero: begin
        res_nxt    = operand_r + exec_pkg::BYTE_ONE;
        to_acc_nxt = 1'b1;
        skip_nxt   = (res_nxt == exec_pkg::BYTE_ZERO);
      end
      exec_pkg::inc_reg_skip_if_zero: begin
        res_nxt    = operand_r + exec_pkg::BYTE_ONE;
        to_reg_nxt = 1'b1;
        skip_nxt   = (res_nxt == exec_pkg::BYTE_ZERO);
      end
      exec_pkg::dec_to_acc_skip_if_zero: begin
        res_nxt    = operand_r - exec_pkg::BYTE_ONE;
        to_acc_nxt = 1'b1;
        skip_nxt   = (res_nxt == exec_pkg::BYTE_ZERO);
      end
      exec_pkg::dec_reg_skip_if_zero: begin
        res_nxt    = operand_r - exec_pkg::BYTE_ONE;
        to_reg_nxt = 1'b1;
        skip_nxt   = (res_nxt == exec_pkg::BYTE_ZERO);
      end
      exec_pkg::test_for_zero: begin
        upd_zero_nxt = 1'b1;
      end
      exec_pkg::xor_immediate_to_acc,
      exec_pkg::xor_reg_to_acc: begin
        res_nxt      = operand_r ^ acc_r;
        to_acc_nxt   = 1'b1;
        upd_zero_nxt = 1'b1;
      end
      exec_pkg::xor_reg_to_reg: begin
        res_nxt      = operand_r ^ acc_r;
        to_reg_nxt   = 1'b1;
        upd_zero_nxt = 1'b1;
      end
      default: begin
        res_nxt = operand_r;
      end
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      exec_pkg::ST_IDLE: begin
        if (start) begin
          state_nxt = exec_pkg::ST_EXEC;
        end
      end
      exec_pkg::ST_EXEC: begin
        if (lookup_op) begin
          state_nxt = exec_pkg::ST_TABLE;
        end else if (skip_nxt) begin
          state_nxt = exec_pkg::ST_DISCARD;
        end else begin
          state_nxt = exec_pkg::ST_IDLE;
        end
      end
      exec_pkg::ST_TABLE:   state_nxt = exec_pkg::ST_IDLE;
      exec_pkg::ST_DISCARD: state_nxt = exec_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= exec_pkg::ST_IDLE;
      busy_o  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      busy_o  <= (state_nxt != exec_pkg::ST_IDLE);
    end
  end

  // Accumulator; software writes only land while idle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_r <= exec_pkg::BYTE_ZERO;
    end else if (exec && to_acc_nxt) begin
      acc_r <= res_nxt;
    end else if (state_r == exec_pkg::ST_TABLE && op_r == exec_pkg::lookup_to_acc) begin
      acc_r <= pmem_data_i[exec_pkg::DATA_W-1:0];
    end else if (wr_req && idle && wb_adr_i == exec_pkg::OFF_ACC && wb_sel_i[0]) begin
      acc_r <= wb_dat_i[exec_pkg::DATA_W-1:0];
    end
  end

  // Register write-back strobe, one cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      file_we_o    <= 1'b0;
      file_wdata_o <= exec_pkg::BYTE_ZERO;
    end else if (exec && to_reg_nxt) begin
      file_we_o    <= 1'b1;
      file_wdata_o <= res_nxt;
    end else if (state_r == exec_pkg::ST_TABLE && op_r == exec_pkg::lookup_to_reg) begin
      file_we_o    <= 1'b1;
      file_wdata_o <= pmem_data_i[exec_pkg::DATA_W-1:0];
    end else begin
      file_we_o    <= 1'b0;
    end
  end

  // Program memory port
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pmem_addr_o <= exec_pkg::PADDR_ZERO;
      pmem_rd_o   <= 1'b0;
    end else begin
      pmem_rd_o <= exec && lookup_op;
      if (exec && lookup_op) begin
        pmem_addr_o <= {ptr_high_r, ptr_low_r};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lookup_high_r <= exec_pkg::HIGH_ZERO;
    end else if (state_r == exec_pkg::ST_TABLE) begin
      lookup_high_r <= pmem_data_i[exec_pkg::PMEM_W-1:exec_pkg::DATA_W];
    end
  end

  // Only xor and test touch the flag; skips leave it alone
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      zero_r <= 1'b0;
    end else if (exec && upd_zero_nxt) begin
      zero_r <= (res_nxt == exec_pkg::BYTE_ZERO);
    end
  end

  // Skip marks the discard cycle that drops the fetched word
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      skip_o        <= 1'b0;
      skip_last_r   <= 1'b0;
      reg_wr_last_r <= 1'b0;
    end else begin
      skip_o <= exec && !lookup_op && skip_nxt;
      if (exec) begin
        skip_last_r   <= !lookup_op && skip_nxt;
        reg_wr_last_r <= to_reg_nxt || (op_r == exec_pkg::lookup_to_reg);
      end
    end
  end

  property p_bit_clear;
    @(posedge clk) disable iff (!rst_n)
      exec && op_r == exec_pkg::skip_if_bit_clear
      |=> skip_o == !$past(operand_r[bit_sel_r]);
  endproperty
  a_bit_clear: assert property (p_bit_clear) else $error("bit clear skip wrong");

  property p_bit_set;
    @(posedge clk) disable iff (!rst_n)
      exec && op_r == exec_pkg::skip_if_bit_set && !operand_r[bit_sel_r]
      |=> !skip_o && idle && $stable(zero_r);
  endproperty
  a_bit_set: assert property (p_bit_set) else $error("bit set skip taken wrongly");

  property p_load_acc;
    @(posedge clk) disable iff (!rst_n)
      exec && op_r == exec_pkg::load_acc_skip_if_zero
      |=> acc_r == $past(operand_r) && skip_o == (acc_r == exec_pkg::BYTE_ZERO);
  endproperty
  a_load_acc: assert property (p_load_acc) else $error("load and test wrong");

  property p_inc_acc;
    @(posedge clk) disable iff (!rst_n)
      exec && op_r == exec_pkg::inc_to_acc_skip_if_zero
      |=> acc_r == 8'($past(operand_r) + exec_pkg::BYTE_ONE) && !file_we_o;
  endproperty
  a_inc_acc: assert property (p_inc_acc) else $error("increment to acc wrong");

  property p_dec_reg;
    @(posedge clk) disable iff (!rst_n)
      exec && op_r == exec_pkg::dec_reg_skip_if_zero
      |=> file_we_o && file_wdata_o == 8'($past(operand_r) - exec_pkg::BYTE_ONE)
          && skip_o == (file_wdata_o == exec_pkg::BYTE_ZERO);
  endproperty
  a_dec_reg: assert property (p_dec_reg) else $error("decrement to register wrong");

  property p_lookup_addr;
    @(posedge clk) disable iff (!rst_n)
      exec && lookup_op
      |=> pmem_rd_o && pmem_addr_o == {$past(ptr_high_r), $past(ptr_low_r)}
          ##1 idle && !pmem_rd_o;
  endproperty
  a_lookup_addr: assert property (p_lookup_addr) else $error("lookup address wrong");

  property p_lookup_reg;
    @(posedge clk) disable iff (!rst_n)
      state_r == exec_pkg::ST_TABLE && op_r == exec_pkg::lookup_to_reg
      |=> file_we_o && file_wdata_o == $past(pmem_data_i[exec_pkg::DATA_W-1:0])
          && lookup_high_r == $past(pmem_data_i[exec_pkg::PMEM_W-1:exec_pkg::DATA_W]);
  endproperty
  a_lookup_reg: assert property (p_lookup_reg) else $error("lookup to register wrong");

  property p_xor_acc;
    @(posedge clk) disable iff (!rst_n)
      exec && op_r == exec_pkg::xor_reg_to_acc
      |=> acc_r == ($past(operand_r) ^ $past(acc_r)) && zero_r == (acc_r == exec_pkg::BYTE_ZERO);
  endproperty
  a_xor_acc: assert property (p_xor_acc) else $error("xor to acc wrong");

  property p_xor_reg;
    @(posedge clk) disable iff (!rst_n)
      exec && op_r == exec_pkg::xor_reg_to_reg
      |=> file_wdata_o == ($past(operand_r) ^ $past(acc_r)) && $stable(acc_r) && idle;
  endproperty
  a_xor_reg: assert property (p_xor_reg) else $error("xor to register wrong");

  property p_test;
    @(posedge clk) disable iff (!rst_n)
      exec && op_r == exec_pkg::test_for_zero
      |=> $stable(acc_r) && !file_we_o && zero_r == ($past(operand_r) == exec_pkg::BYTE_ZERO);
  endproperty
  a_test: assert property (p_test) else $error("test instruction wrong");

  property p_skip_len;
    @(posedge clk) disable iff (!rst_n)
      $rose(skip_o) |-> state_r == exec_pkg::ST_DISCARD ##1 idle && !skip_o;
  endproperty
  a_skip_len: assert property (p_skip_len) else $error("skip cycle count wrong");

endmodule : skip_lookup_xor_execute

`default_nettype wire

// ### tb/tb.sv
// Purpose: Self-checking bench for the skip, lookup and xor execute unit
// Assumes: One bus request at a time, answered a cycle after it is taken
// Notes:   Program memory lives here; it shows an inverted word when not read
`timescale 1ns/1ps
`default_nettype none

module tb;
  typedef struct packed {
    logic [3:0] op;
    logic [2:0] bsel;
    logic [7:0] opnd;
    logic [7:0] acc;
    logic [7:0] exp_acc;
    logic       exp_we;
    logic [7:0] exp_wd;
    logic       exp_skip;
    logic       upd_z;
    logic       exp_z;
  } row_t;

  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] dat_o;
  logic        ack;
  logic [15:0] pmem_addr;
  logic        pmem_rd;
  logic [15:0] pmem_data;
  logic        file_we;
  logic [7:0]  file_wd;
  logic        skip;
  logic        busy;
  int          n_fail = 0;
  int          num_checks = 0;
  int          n_skip = 0;
  int          n_we = 0;
  int          n_busy = 0;
  logic [15:0] last_pa = 16'h0000;
  logic        zf = 1'b0;
  logic [31:0] q;
  int          ds;
  int          dw;
  int          db;

  // Program words; 0115 holds 1234, the rest are scrambled so halves differ unless the address bytes xor to 99
  function automatic logic [15:0] word_at(input logic [15:0] a);
    word_at = (a == 16'h0115) ? 16'h1234 : {a[7:0] ^ 8'h5A, a[15:8] ^ 8'hC3};
  endfunction : word_at

  // Idle memory drives the inverse so a stale sample cannot pass
  assign pmem_data = pmem_rd ? word_at(pmem_addr) : ~word_at(pmem_addr);

  always #5 clk = ~clk;

  always @(posedge clk) begin
    if (skip === 1'b1) n_skip++;
    if (file_we === 1'b1) n_we++;
    if (busy === 1'b1) n_busy++;
    if (pmem_rd === 1'b1) last_pa = pmem_addr;
  end

  skip_lookup_xor_execute i_skip_lookup_xor_execute (
    .clk          (clk),
    .rst_n        (rst_n),
    .wb_cyc_i     (cyc),
    .wb_stb_i     (stb),
    .wb_we_i      (we),
    .wb_adr_i     (adr),
    .wb_sel_i     (sel),
    .wb_dat_i     (dat),
    .wb_dat_o     (dat_o),
    .wb_ack_o     (ack),
    .pmem_addr_o  (pmem_addr),
    .pmem_rd_o    (pmem_rd),
    .pmem_data_i  (pmem_data),
    .file_we_o    (file_we),
    .file_wdata_o (file_wd),
    .skip_o       (skip),
    .busy_o       (busy)
  );

  task automatic summarize();
    if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  // Request held until the edge that samples ack, then released
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
                         input logic [31:0] d, output logic [31:0] r);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    if (k == 20) begin
      check("bus answer", 32'h0000_0000, 32'h0000_0001);
      summarize();
    end
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb_xfer

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    wb_xfer(1'b1, a, 4'h1, {24'h000000, d}, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    wb_xfer(1'b0, a, 4'h0, 32'h0000_0000, r);
  endtask : rd

  // Starts one instruction and returns pulse and busy counts it produced
  task automatic run_op(input logic [3:0] op, input logic [2:0] b);
    int s0;
    int w0;
    int b0;
    int k;
    logic [31:0] r;
    s0 = n_skip;
    w0 = n_we;
    b0 = n_busy;
    wb_xfer(1'b1, exec_pkg::OFF_CTRL, 4'h3, {21'h000000, b, 4'h0, op}, r);
    for (k = 0; k < 20; k++) begin
      @(posedge clk);
      if (busy === 1'b0) break;
    end
    if (k == 20) begin
      check("busy release", 32'h0000_0000, 32'h0000_0001);
      summarize();
    end
    @(posedge clk);
    ds = n_skip - s0;
    dw = n_we - w0;
    db = n_busy - b0;
  endtask : run_op

  // op bit operand acc | acc we wdata skip | zero-update zero
  row_t rows [22] = '{
    '{4'h0, 3'h0, 8'h12, 8'hCD, 8'hCD, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0},
    '{4'h1, 3'h3, 8'hF7, 8'h11, 8'h11, 1'b0, 8'h00, 1'b1, 1'b0, 1'b0},
    '{4'h1, 3'h3, 8'h08, 8'h11, 8'h11, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0},
    '{4'h2, 3'h7, 8'h80, 8'h22, 8'h22, 1'b0, 8'h00, 1'b1, 1'b0, 1'b0},
    '{4'h2, 3'h0, 8'hFE, 8'h22, 8'h22, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0},
    '{4'h3, 3'h0, 8'h00, 8'h33, 8'h00, 1'b0, 8'h00, 1'b1, 1'b0, 1'b0},
    '{4'h3, 3'h0, 8'h5A, 8'h33, 8'h5A, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0},
    '{4'h4, 3'h0, 8'h00, 8'h44, 8'h44, 1'b1, 8'h00, 1'b1, 1'b0, 1'b0},
    '{4'h4, 3'h0, 8'h81, 8'h44, 8'h44, 1'b1, 8'h81, 1'b0, 1'b0, 1'b0},
    '{4'h5, 3'h0, 8'hFF, 8'h55, 8'h00, 1'b0, 8'h00, 1'b1, 1'b0, 1'b0},
    '{4'h5, 3'h0, 8'h0A, 8'h55, 8'h0B, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0},
    '{4'h6, 3'h0, 8'hFF, 8'h66, 8'h66, 1'b1, 8'h00, 1'b1, 1'b0, 1'b0},
    '{4'h7, 3'h0, 8'h01, 8'h77, 8'h00, 1'b0, 8'h00, 1'b1, 1'b0, 1'b0},
    '{4'h8, 3'h0, 8'h00, 8'h88, 8'h88, 1'b1, 8'hFF, 1'b0, 1'b0, 1'b0},
    '{4'h8, 3'h0, 8'h01, 8'h88, 8'h88, 1'b1, 8'h00, 1'b1, 1'b0, 1'b0},
    '{4'hC, 3'h0, 8'h0F, 8'h0A, 8'h05, 1'b0, 8'h00, 1'b0, 1'b1, 1'b0},
    '{4'hB, 3'h0, 8'h00, 8'h99, 8'h99, 1'b0, 8'h00, 1'b0, 1'b1, 1'b1},
    '{4'h6, 3'h0, 8'h10, 8'h99, 8'h99, 1'b1, 8'h11, 1'b0, 1'b0, 1'b0},
    '{4'hD, 3'h0, 8'hA5, 8'h5A, 8'hFF, 1'b0, 8'h00, 1'b0, 1'b1, 1'b0},
    '{4'hE, 3'h0, 8'h3C, 8'h3C, 8'h3C, 1'b1, 8'h00, 1'b0, 1'b1, 1'b1},
    '{4'hB, 3'h0, 8'h80, 8'h3C, 8'h3C, 1'b0, 8'h00, 1'b0, 1'b1, 1'b0},
    '{4'hF, 3'h0, 8'h00, 8'hAB, 8'hAB, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0}
  };

  initial begin
    repeat (3) @(posedge clk);
    check("outputs in reset",
          {3'h0, file_wd, pmem_addr, ack, busy, skip, file_we, pmem_rd}, 32'h0);
    check("read data in reset", dat_o, 32'h0);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      wr(exec_pkg::OFF_ACC, rows[i].acc);
      wr(exec_pkg::OFF_OPERAND, rows[i].opnd);
      run_op(rows[i].op, rows[i].bsel);
      if (rows[i].upd_z) zf = rows[i].exp_z;
      rd(exec_pkg::OFF_ACC, q);
      check("accumulator", q, {24'h0, rows[i].exp_acc});
      check("write-back pulses", 32'(dw), {31'h0, rows[i].exp_we});
      if (rows[i].exp_we) begin
        check("write-back port", {24'h0, file_wd}, {24'h0, rows[i].exp_wd});
        rd(exec_pkg::OFF_RESULT, q);
        check("write-back value", q, {24'h0, rows[i].exp_wd});
      end
      check("skip pulses", 32'(ds), {31'h0, rows[i].exp_skip});
      if (rows[i].op != 4'hF) begin
        check("busy cycles", 32'(db), rows[i].exp_skip ? 32'h2 : 32'h1);
      end
      rd(exec_pkg::OFF_STATUS, q);
      check("status", {29'h0, q[3:1]}, {29'h0, rows[i].exp_we, rows[i].exp_skip, zf});
    end
    // Lookup through the example pointer, then pointer FF00 at the start of the top page
    wr(exec_pkg::OFF_PTR_HIGH, 8'h01);
    wr(exec_pkg::OFF_PTR_LOW, 8'h15);
    wr(exec_pkg::OFF_ACC, 8'h00);
    run_op(4'hA, 3'h0);
    check("lookup address", {16'h0, last_pa}, 32'h0000_0115);
    check("lookup cycles", 32'(db), 32'h2);
    rd(exec_pkg::OFF_ACC, q);
    check("lookup low", q, 32'h0000_0034);
    rd(exec_pkg::OFF_LOOKUP_HIGH, q);
    check("lookup high", q, 32'h0000_0012);
    wr(exec_pkg::OFF_PTR_HIGH, 8'hFF);
    wr(exec_pkg::OFF_PTR_LOW, 8'h00);
    rd(exec_pkg::OFF_PTR_HIGH, q);
    check("pointer readback", q, 32'h0000_00FF);
    wr(exec_pkg::OFF_ACC, 8'h77);
    run_op(4'h9, 3'h0);
    check("lookup address", {16'h0, last_pa}, 32'h0000_FF00);
    check("lookup pulses", {26'h0, 3'(db), 3'(dw)}, {26'h0, 3'h2, 3'h1});
    rd(exec_pkg::OFF_RESULT, q);
    check("lookup low", q, {16'h0, word_at(16'hFF00) & 16'h00FF});
    rd(exec_pkg::OFF_LOOKUP_HIGH, q);
    check("lookup high", q, {16'h0, word_at(16'hFF00) >> 8});
    rd(exec_pkg::OFF_ACC, q);
    check("accumulator kept", q, 32'h0000_0077);
    rd(exec_pkg::OFF_CTRL, q);
    check("command readback", q, 32'h0000_0009);
    // Read-only write, lane-0-off write and unmapped read are all harmless
    wr(exec_pkg::OFF_LOOKUP_HIGH, 8'hEE);
    rd(exec_pkg::OFF_LOOKUP_HIGH, q);
    check("read-only high", q, {16'h0, word_at(16'hFF00) >> 8});
    wb_xfer(1'b1, exec_pkg::OFF_ACC, 4'h2, 32'h0000_00C3, q);
    rd(exec_pkg::OFF_ACC, q);
    check("masked write", q, 32'h0000_0077);
    rd(8'h20, q);
    check("unmapped read", q, 32'h0000_0000);
    // Second reset in mid-run clears the accumulator
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    rd(exec_pkg::OFF_ACC, q);
    check("accumulator after reset", q, 32'h0000_0000);
    rd(exec_pkg::OFF_STATUS, q);
    check("status after reset", q, 32'h0000_0000);
    rd(exec_pkg::OFF_PTR_HIGH, q);
    check("pointer after reset", q, 32'h0000_0000);
    summarize();
  end
endmodule : tb

`default_nettype wire
